/* pkg/embedded_block_ram_pkg.sv */
package embedded_block_ram_pkg;
   // storage array size and port limits
   localparam int MEM_BITS = 9216;
   localparam int MAX_W = 36;
   localparam int ADDR_W = 13;
   localparam int BIT_W = 14;
   localparam int INIT_W = 9;
   localparam int INIT_ADDR_W = 10;
   // capacity of the shapes that use the ninth bits, and of the others
   localparam logic [BIT_W-1:0] CAP_WIDE = 14'h2400;
   localparam logic [BIT_W-1:0] CAP_NARROW = 14'h2000;

   // operating mode of the block
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_TRUE_DUAL = 2'h1,
      MODE_PSEUDO_DUAL = 2'h2,
      MODE_FIFO = 2'h3
   } mode_t;

   // port shape: depth x width
   typedef enum logic [2:0] {
      SHAPE_8192X1 = 3'h0,
      SHAPE_4096X2 = 3'h1,
      SHAPE_2048X4 = 3'h2,
      SHAPE_1024X9 = 3'h3,
      SHAPE_512X18 = 3'h4,
      SHAPE_256X36 = 3'h5
   } shape_t;

   // word width in bits of a shape
   function automatic logic [BIT_W-1:0] width_of(input shape_t s);
      case (s)
         SHAPE_8192X1: width_of = 14'h0001;
         SHAPE_4096X2: width_of = 14'h0002;
         SHAPE_2048X4: width_of = 14'h0004;
         SHAPE_1024X9: width_of = 14'h0009;
         SHAPE_512X18: width_of = 14'h0012;
         SHAPE_256X36: width_of = 14'h0024;
         default: width_of = 14'h0001;
      endcase
   endfunction : width_of

   // address mask giving the depth of a shape
   function automatic logic [ADDR_W-1:0] mask_of(input shape_t s);
      case (s)
         SHAPE_8192X1: mask_of = 13'h1FFF;
         SHAPE_4096X2: mask_of = 13'h0FFF;
         SHAPE_2048X4: mask_of = 13'h07FF;
         SHAPE_1024X9: mask_of = 13'h03FF;
         SHAPE_512X18: mask_of = 13'h01FF;
         SHAPE_256X36: mask_of = 13'h00FF;
         default: mask_of = 13'h1FFF;
      endcase
   endfunction : mask_of

   // bits usable by a shape; the ninth-bit shapes reach the whole array
   function automatic logic [BIT_W-1:0] cap_of(input shape_t s);
      cap_of = (s == SHAPE_1024X9 || s == SHAPE_512X18 || s == SHAPE_256X36) ?
         CAP_WIDE : CAP_NARROW;
   endfunction : cap_of
endpackage : embedded_block_ram_pkg

/* rtl/embedded_block_ram.sv */
module embedded_block_ram (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // configuration
   input wire embedded_block_ram_pkg::mode_t mode,
   input wire embedded_block_ram_pkg::shape_t shape_a,
   input wire embedded_block_ram_pkg::shape_t shape_b,
   input wire logic out_reg_en,
   output logic cfg_error,
   // preload during configuration
   input wire logic init_load,
   input wire logic [embedded_block_ram_pkg::INIT_ADDR_W-1:0] init_addr,
   input wire logic [embedded_block_ram_pkg::INIT_W-1:0] init_data,
   // port a (write side of pseudo dual and FIFO)
   input wire logic a_ce,
   input wire logic a_we,
   input wire logic [embedded_block_ram_pkg::ADDR_W-1:0] a_addr,
   input wire logic [embedded_block_ram_pkg::MAX_W-1:0] a_din,
   output logic [embedded_block_ram_pkg::MAX_W-1:0] a_dout,
   // port b (read side of pseudo dual and FIFO)
   input wire logic b_ce,
   input wire logic b_we,
   input wire logic [embedded_block_ram_pkg::ADDR_W-1:0] b_addr,
   input wire logic [embedded_block_ram_pkg::MAX_W-1:0] b_din,
   output logic [embedded_block_ram_pkg::MAX_W-1:0] b_dout,
   // FIFO flags
   output logic fifo_full,
   output logic fifo_empty
);
   import embedded_block_ram_pkg::*;

   // one bit per cell, so every port width maps onto the same cells
   logic mem [0:MEM_BITS-1];
   logic [BIT_W-1:0] wa, wb, cap;
   logic a_ok, b_ok, push, pop;
   // input stage registers
   logic [BIT_W-1:0] a_base, b_base, next_a_base, next_b_base;
   logic [MAX_W-1:0] a_wdata, b_wdata, next_a_wdata, next_b_wdata;
   logic a_wr, b_wr, next_a_wr, next_b_wr;
   logic [BIT_W-1:0] a_wlen, b_wlen, b_rlen, a_rlen;
   logic [BIT_W-1:0] next_a_wlen, next_b_wlen, next_a_rlen, next_b_rlen;
   logic a_rd, b_rd, next_a_rd, next_b_rd;
   // array and output registers
   logic [MAX_W-1:0] arr_a, arr_b, next_arr_a, next_arr_b;
   logic [MAX_W-1:0] out_a, out_b, next_out_a, next_out_b;
   // FIFO pointers in bits
   logic [BIT_W-1:0] wr_ptr, rd_ptr, fill, next_wr_ptr, next_rd_ptr, next_fill;

   // port widths and legality of the chosen shapes
   always_comb begin
      wa = width_of(shape_a);
      wb = (mode == MODE_SINGLE) ? wa : width_of(shape_b);
      cap = cap_of(shape_a);
      // true dual has no x36 shape; such a setting blocks both ports
      cfg_error = (mode == MODE_TRUE_DUAL) &&
         (shape_a == SHAPE_256X36 || shape_b == SHAPE_256X36);
      a_ok = a_ce && !cfg_error;
      b_ok = b_ce && !cfg_error && (mode != MODE_SINGLE);
      // a push needs room for a whole port a word, a pop a whole port b word
      fifo_full = (fill + wa) > cap;
      fifo_empty = fill < wb;
      push = (mode == MODE_FIFO) && a_ok && a_we && !fifo_full;
      pop = (mode == MODE_FIFO) && b_ok && !fifo_empty;
   end

   // input registers: bit base, data and strobes per port
   always_comb begin
      // bit address of a word: word index times port width
      next_a_base = BIT_W'(a_addr & mask_of(shape_a)) * wa;
      next_b_base = BIT_W'(b_addr & mask_of(shape_b)) * wb;
      if (mode == MODE_SINGLE) begin
         next_b_base = next_a_base;
      end
      next_a_wdata = a_din;
      next_b_wdata = b_din;
      next_a_wlen = wa;
      next_b_wlen = wb;
      next_a_rlen = wa;
      next_b_rlen = wb;
      // port a writes in every mode; it reads only in single and true dual mode
      next_a_wr = a_ok && a_we;
      next_b_wr = b_ok && b_we && (mode == MODE_TRUE_DUAL);
      next_a_rd = a_ok && !a_we && (mode == MODE_SINGLE || mode == MODE_TRUE_DUAL);
      // port b reads whenever enabled outside single mode, except while it writes in true dual mode
      next_b_rd = b_ok && (mode != MODE_TRUE_DUAL || !b_we);
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_fill = fill;
      if (mode == MODE_FIFO) begin
         // FIFO walks the array by its own pointers
         next_a_base = wr_ptr;
         next_b_base = rd_ptr;
         next_a_wr = push;
         next_a_rd = 1'b0;
         next_b_rd = pop;
         next_b_wr = 1'b0;
         // pointers wrap at the capacity keeping the overshoot; bits of a word past it stay above the capacity, not at the start
         if (push) begin
            next_wr_ptr = (wr_ptr + wa >= cap) ? BIT_W'(wr_ptr + wa - cap) : BIT_W'(wr_ptr + wa);
         end
         if (pop) begin
            next_rd_ptr = (rd_ptr + wb >= cap) ? BIT_W'(rd_ptr + wb - cap) : BIT_W'(rd_ptr + wb);
         end
         next_fill = BIT_W'(fill + (push ? wa : '0) - (pop ? wb : '0));
      end else begin
         // outside FIFO mode the pointers rest at zero, so the FIFO starts empty
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_fill = '0;
      end
   end

   // input stage and FIFO pointer registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         a_base <= '0;
         b_base <= '0;
         a_wdata <= '0;
         b_wdata <= '0;
         a_wr <= 1'b0;
         b_wr <= 1'b0;
         a_rd <= 1'b0;
         b_rd <= 1'b0;
         a_wlen <= '0;
         b_wlen <= '0;
         a_rlen <= '0;
         b_rlen <= '0;
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end else begin
         a_base <= next_a_base;
         b_base <= next_b_base;
         a_wdata <= next_a_wdata;
         b_wdata <= next_b_wdata;
         a_wr <= next_a_wr;
         b_wr <= next_b_wr;
         a_rd <= next_a_rd;
         b_rd <= next_b_rd;
         a_wlen <= next_a_wlen;
         b_wlen <= next_b_wlen;
         a_rlen <= next_a_rlen;
         b_rlen <= next_b_rlen;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fill <= next_fill;
      end
   end

   // array write: preload shuts out both ports; otherwise port b, then port a wins on overlap
   always_ff @(posedge sys_clk) begin
      if (init_load) begin
         for (int i = 0; i < INIT_W; i++) begin
            if (int'(init_addr) * INIT_W + i < MEM_BITS) begin
               mem[int'(init_addr) * INIT_W + i] <= init_data[i];
            end
         end
      end else begin
         // with a_we and b_we held low nothing lands here and the block is a ROM
         for (int i = 0; i < MAX_W; i++) begin
            if (b_wr && i < int'(b_wlen) && int'(b_base) + i < MEM_BITS) begin
               mem[int'(b_base) + i] <= b_wdata[i];
            end
            if (a_wr && i < int'(a_wlen) && int'(a_base) + i < MEM_BITS) begin
               mem[int'(a_base) + i] <= a_wdata[i];
            end
         end
      end
   end

   // array read, old contents on a same-address write
   always_comb begin
      next_arr_a = arr_a;
      next_arr_b = arr_b;
      // bits above the port width read as zero
      if (a_rd) begin
         for (int i = 0; i < MAX_W; i++) begin
            next_arr_a[i] = (i < int'(a_rlen) && int'(a_base) + i < MEM_BITS) ?
               mem[int'(a_base) + i] : 1'b0;
         end
      end
      if (b_rd) begin
         for (int i = 0; i < MAX_W; i++) begin
            next_arr_b[i] = (i < int'(b_rlen) && int'(b_base) + i < MEM_BITS) ?
               mem[int'(b_base) + i] : 1'b0;
         end
      end
      next_out_a = arr_a;
      next_out_b = arr_b;
   end

   // array read stage, then the optional output stage one clock later
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         arr_a <= '0;
         arr_b <= '0;
         out_a <= '0;
         out_b <= '0;
      end else begin
         arr_a <= next_arr_a;
         arr_b <= next_arr_b;
         out_a <= next_out_a;
         out_b <= next_out_b;
      end
   end

   // output register selected or bypassed
   // both mux sources are flip-flops; the mux only picks a stage
   assign a_dout = out_reg_en ? out_a : arr_a;
   assign b_dout = out_reg_en ? out_b : arr_b;
endmodule : embedded_block_ram

/* testbench/embedded_block_ram_checker.sv */
module embedded_block_ram_checker (
   // watched ports
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire embedded_block_ram_pkg::mode_t mode,
   input wire embedded_block_ram_pkg::shape_t shape_a,
   input wire embedded_block_ram_pkg::shape_t shape_b,
   input wire logic out_reg_en,
   input wire logic cfg_error,
   input wire logic a_ce,
   input wire logic a_we,
   input wire logic [embedded_block_ram_pkg::MAX_W-1:0] a_dout,
   input wire logic b_ce,
   input wire logic [embedded_block_ram_pkg::MAX_W-1:0] b_dout,
   input wire logic fifo_full,
   input wire logic fifo_empty
);
   timeunit 1ns;
   timeprecision 1ps;
   import embedded_block_ram_pkg::*;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // accepted accesses, and fifo mode settled for two clocks
   logic rd_a, rd_b, fifo;
   logic [1:0] hist, next_hist;
   assign rd_a = a_ce & !cfg_error;
   assign rd_b = (b_ce | (a_ce & mode == MODE_SINGLE)) & !cfg_error;
   assign fifo = mode == MODE_FIFO && &hist;
   always_comb next_hist = {hist[0], mode == MODE_FIFO};
   always_ff @(posedge sys_clk) hist <= next_hist;

   a_cfg_x36: assert property (
      cfg_error == (mode == MODE_TRUE_DUAL && (shape_a == SHAPE_256X36 || shape_b == SHAPE_256X36)))
      else $error("cfg_error wrong");
   a_hold_a: assert property (!$past(rd_a) && !$past(rd_a, 2) && !$past(rd_a, 3) &&
      $stable(out_reg_en) && $stable(mode) && $stable(shape_a) |-> $stable(a_dout))
      else $error("a_dout moved with no read");
   a_hold_b: assert property (!$past(rd_b) && !$past(rd_b, 2) && !$past(rd_b, 3) &&
      $stable(out_reg_en) && $stable(mode) && $stable({shape_a, shape_b}) |-> $stable(b_dout))
      else $error("b_dout moved with no read");
   a_flags_excl: assert property (fifo |-> !(fifo_full && fifo_empty))
      else $error("full and empty together");
   a_push_fill: assert property (fifo && fifo_empty && a_ce && a_we && !b_ce &&
      shape_a == shape_b |=> !fifo_empty) else $error("push left fifo empty");
   a_pop_empty: assert property (fifo && fifo_empty && b_ce && !a_ce |=> fifo_empty)
      else $error("pop on empty changed fill");
   a_full_push: assert property (fifo && fifo_full && a_ce && a_we && !b_ce |=> fifo_full)
      else $error("push on full changed fill");
   a_idle_flags: assert property (fifo && !a_ce && !b_ce |=>
      $stable(fifo_full) && $stable(fifo_empty)) else $error("flags moved while idle");
endmodule : embedded_block_ram_checker

bind embedded_block_ram embedded_block_ram_checker chk (.sys_clk, .rst_n, .mode, .shape_a,
   .shape_b, .out_reg_en, .cfg_error, .a_ce, .a_we, .a_dout, .b_ce, .b_dout, .fifo_full,
   .fifo_empty);

/* testbench/fabric_port_b.sv */
module fabric_port_b (
   // clock, reset and command
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [12:0] addr,
   input wire logic [8:0] len,
   // port b of the block
   output logic b_ce,
   output logic [12:0] b_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] left;
   // enable held len clocks; once released the address is inverted again on every clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         left <= 9'h000;
         b_addr <= 13'h0000;
      end else begin
         left <= go ? len : left - 9'(left != 9'h000);
         b_addr <= go ? addr : (left > 9'h001) ? b_addr : ~b_addr;
      end
   end
   assign b_ce = left != 9'h000;
endmodule : fabric_port_b

/* testbench/embedded_block_ram_tb.sv */
module embedded_block_ram_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import embedded_block_ram_pkg::*;
   // stimulus and observed signals
   logic sys_clk = '0, rst_n = '0, out_reg_en = '0, init_load = '0, a_ce = '0, a_we = '0;
   logic b_we = '0, p_go = '0, b_ce, cfg_error, fifo_full, fifo_empty;
   mode_t mode = MODE_SINGLE;
   shape_t shape_a = SHAPE_1024X9, shape_b = SHAPE_1024X9;
   logic [INIT_ADDR_W-1:0] init_addr = '0;
   logic [INIT_W-1:0] init_data = '0;
   logic [ADDR_W-1:0] a_addr = '0, p_addr = '0, b_addr;
   logic [MAX_W-1:0] a_din = '0, b_din = '0, a_dout, b_dout;
   logic [8:0] p_len = '0;
   int mismatches = 0, checks = 0, cyc = 0;

   embedded_block_ram dut (.sys_clk, .rst_n, .mode, .shape_a, .shape_b, .out_reg_en, .cfg_error,
      .init_load, .init_addr, .init_data, .a_ce, .a_we, .a_addr, .a_din, .a_dout, .b_ce, .b_we,
      .b_addr, .b_din, .b_dout, .fifo_full, .fifo_empty);
   fabric_port_b partner (.sys_clk, .rst_n, .go(p_go), .addr(p_addr), .len(p_len), .b_ce,
      .b_addr);

   // clock and hang guard
   initial forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         results();
      end
   end

   task automatic clk(int n = 1);
      repeat (n) @(posedge sys_clk);
   endtask : clk
   task automatic cmp(string n, logic [MAX_W-1:0] e, logic [MAX_W-1:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : cmp
   // one port a access per clock; back to back calls keep the enable up
   task automatic acc_a(logic we, logic [ADDR_W-1:0] ad, logic [MAX_W-1:0] d);
      a_ce <= 1'h1;
      a_we <= we;
      a_addr <= ad;
      a_din <= d;
      clk();
   endtask : acc_a
   // read and check exactly at the port latency
   task automatic rd_a(logic [ADDR_W-1:0] ad, logic [MAX_W-1:0] e);
      acc_a(1'h0, ad, '0);
      a_ce <= 1'h0;
      clk(1 + out_reg_en);
      #1 cmp("a_dout", e, a_dout);
      clk();
   endtask : rd_a
   task automatic rd_b(logic [ADDR_W-1:0] ad, logic [8:0] n, logic [MAX_W-1:0] e);
      p_addr <= ad;
      p_len <= n;
      p_go <= 1'h1;
      clk();
      p_go <= 1'h0;
      clk(2 + out_reg_en);
      #1 cmp("b_dout", e, b_dout);
      clk();
   endtask : rd_b

   // every mode and shape; only true dual with x36 is refused
   task automatic t_cfg;
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 6; s++) begin
            mode <= mode_t'(m);
            shape_a <= shape_t'(s);
            shape_b <= shape_t'(s);
            #1 cmp("cfg_error", 36'(m == 1 && s == 5), cfg_error);
            clk();
         end
      end
      mode <= MODE_TRUE_DUAL;
      acc_a(1'h0, '0, '0);
      a_ce <= 1'h0;
      clk(3);
      #1 cmp("a_dout", '0, a_dout);
      clk();
      $display("test cfg done");
   endtask : t_cfg
   // registered address, bypassed then registered output, depth masking
   task automatic t_single;
      mode <= MODE_SINGLE;
      shape_a <= SHAPE_1024X9;
      acc_a(1'h1, 13'h0005, 36'h1C3);
      acc_a(1'h1, 13'h0006, 36'h0A5);
      a_ce <= 1'h0;
      clk();
      rd_a(13'h0405, 36'h1C3);
      out_reg_en <= 1'h1;
      clk();
      rd_a(13'h0006, 36'h0A5);
      out_reg_en <= 1'h0;
      $display("test single done");
   endtask : t_single
   // preloaded groups read as words with writes never enabled
   task automatic t_rom;
      init_load <= 1'h1;
      init_addr <= 10'h002;
      init_data <= 9'h15A;
      clk();
      init_addr <= 10'h003;
      init_data <= 9'h0C7;
      clk();
      init_load <= 1'h0;
      rd_a(13'h0002, 36'h15A);
      shape_a <= SHAPE_512X18;
      clk();
      rd_a(13'h0001, 36'h18F5A);
      $display("test rom done");
   endtask : t_rom
   // x1 writes on a, x4 reads on b with b_we ignored, low bit first
   task automatic t_mixed;
      mode <= MODE_PSEUDO_DUAL;
      b_we <= 1'h1;
      shape_a <= SHAPE_8192X1;
      shape_b <= SHAPE_2048X4;
      for (int i = 0; i < 8; i++) acc_a(1'h1, 13'(i), 36'(8'h3D >> i));
      a_ce <= 1'h0;
      clk();
      rd_b(13'h0000, 9'h001, 36'h00D);
      rd_b(13'h0001, 9'h001, 36'h003);
      $display("test mixed done");
   endtask : t_mixed
   // true dual: x18 write on b, x4 reads on a, then b reads its own word
   task automatic t_dual;
      mode <= MODE_TRUE_DUAL;
      shape_a <= SHAPE_2048X4;
      shape_b <= SHAPE_512X18;
      b_we <= 1'h1;
      b_din <= 36'h2A5C3;
      p_addr <= 13'h0002;
      p_len <= 9'h001;
      p_go <= 1'h1;
      clk();
      p_go <= 1'h0;
      clk(2);
      b_we <= 1'h0;
      rd_a(13'h0009, 36'h3);
      rd_a(13'h000A, 36'hC);
      rd_b(13'h0002, 9'h001, 36'h2A5C3);
      $display("test dual done");
   endtask : t_dual
   // fill until refused, drain one past empty
   task automatic t_fifo;
      mode <= MODE_FIFO;
      shape_a <= SHAPE_256X36;
      shape_b <= SHAPE_256X36;
      clk(2);
      #1 cmp("fifo_empty", 36'h1, fifo_empty);
      clk();
      for (int i = 0; i < 260; i++) acc_a(1'h1, '0, 36'(i + 7));
      a_ce <= 1'h0;
      clk();
      #1 cmp("fifo_full", 36'h1, fifo_full);
      clk();
      rd_b('0, 9'h101, 36'h7);
      clk(258);
      #1 cmp("fifo_empty", 36'h1, fifo_empty);
      clk();
      $display("test fifo done");
   endtask : t_fifo

   task automatic results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   // reset, then the tests in turn
   initial begin
      clk(20);
      rst_n <= 1'h1;
      t_cfg();
      t_single();
      t_rom();
      t_mixed();
      t_dual();
      t_fifo();
      results();
   end
endmodule : embedded_block_ram_tb
